// File: bench/serial_peer.sv
// behavioural serial peer: echoing slave, clock-driving master
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // pins coming from the channel
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic serial_out,
    // pins going to the channel
    output logic sclk_pin,
    output logic data_pin,
    // frame shape
    input wire logic pol,
    input wire logic ph
);
    logic [15:0] cap = 16'h0000;
    logic drv = 1'b0;
    logic clk_q = 1'b0;
    logic in_frame = 1'b0;
    // echo inverted so the pin path and loopback give different words
    assign data_pin = sclk_oe ? ~serial_out : drv;
    // clock stands at idle level between frames
    assign sclk_pin = in_frame ? clk_q : pol;
    // capture on the latching edge of a master frame
    always @(sclk_out) begin
        if (sclk_oe && sclk_out === (pol ^ ph)) begin
            cap = {cap[14:0], serial_out};
        end
    end
    // data changes mid idle half, stable across both edges of either phase
    task automatic send(input logic [15:0] v, input logic [3:0] k, input logic msb);
        in_frame = 1'b1;
        clk_q = pol;
        for (int i = 0; i <= k; i++) begin
            drv = msb ? v[k - i] : v[i];
            #8 clk_q = ~pol;
            #16 clk_q = pol;
            #8;
        end
        in_frame = 1'b0;
        drv = ~drv;
    endtask : send
endmodule : serial_peer
`default_nettype wire

// File: bench/sync_serial_channel_test.sv
// self-checking bench of the serial channel control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, s); end end
module sync_serial_channel_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, sclk_in, sclk_out, sclk_oe;
    logic serial_in, serial_out, serial_oe, peer_sclk, pol, ph, ms, lb, ord;
    logic [1:0] htrans;
    logic [3:0] w;
    logic [15:0] d, m, rx_prev;
    logic [31:0] haddr, hwdata, hrdata, rd, cfg;
    int fails, tests_run;
    // shared clock pin: whoever enables drives it
    assign sclk_in = sclk_oe ? sclk_out : peer_sclk;
    sync_serial_channel u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
        .serial_in(serial_in), .serial_out(serial_out), .serial_oe(serial_oe)
    );
    serial_peer u_peer (
        .sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_out(serial_out), .sclk_pin(peer_sclk),
        .data_pin(serial_in), .pol(pol), .ph(ph)
    );
    // ****************************************
    // bus tasks
    // ****************************************
    task automatic close_out;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic hwait;
        int c;
        c = 0;
        do begin
            @(posedge hclk);
            c++;
        end while (hreadyout !== 1'b1 && c < 40);
        if (c >= 40) begin
            fails++;
            close_out();
        end
    endtask : hwait
    task automatic xf(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hwait();
        htrans <= 2'h0;
        hwdata <= wd;
        hwait();
        rd = hrdata;
    endtask : xf
    task automatic rc;
        xf(sync_serial_pkg::off_control, 1'b0, 32'h0000_0000);
    endtask : rc
    task automatic wc(input logic [31:0] v);
        xf(sync_serial_pkg::off_control, 1'b1, v);
    endtask : wc
    function automatic logic [15:0] rev(input logic [15:0] v, input logic [3:0] k);
        rev = 16'h0000;
        for (int i = 0; i <= k; i++) begin
            rev[i] = v[k - i];
        end
    endfunction : rev
    // two clears: the view lags one write behind the operate bit
    task automatic setup(input logic [15:0] r);
        wc(32'h0000_0000);
        wc(32'h0000_0000);
        pol = cfg[6];
        ph = cfg[5];
        wc(cfg);
        xf(sync_serial_pkg::off_baud_reload, 1'b1, {16'h0000, r});
        rc();
        `CHK("prog view", cfg, rd)
        xf(sync_serial_pkg::off_tx_buffer, 1'b1, {16'h0000, d});
        repeat (20) @(posedge hclk);
        `CHK("idle clock", cfg[6], sclk_out)
        `CHK("data idle", 1'b0, serial_oe)
        `CHK("clock enable", cfg[14], sclk_oe)
        wc(cfg | 32'h0000_8000);
        rc();
        `CHK("late view", cfg | 32'h0000_8000, rd)
        wc(cfg | 32'h0000_8000);
        rc();
        `CHK("op view", (cfg & 32'h0000_4000) | 32'h0000_8000, rd & 32'hfff0_ffff)
        `CHK("data drive", 1'b1, serial_oe)
    endtask : setup
    initial begin
        hclk = 1'b0;
        forever begin
            #2 hclk = ~hclk;
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {hresetn, hsel, hwrite, pol, ph} = 5'h00;
        {haddr, hwdata, htrans} = 66'h0;
        fails = 0;
        tests_run = 0;
        void'($urandom(32'hb3fec727));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc();
        `CHK("ctl reset", 32'h0000_0000, rd)
        xf(8'h00, 1'b0, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        `CHK("unmapped resp", 1'b0, hresp)
        // six master frames, then four slave frames clocked by the peer
        for (int k = 0; k < 10; k++) begin
            ms = (k < 6);
            lb = 1'($urandom);
            ord = 1'($urandom);
            w = 4'(3 + $urandom_range(12));
            d = 16'($urandom);
            m = 16'((32'h2 << w) - 1);
            // tx and rx checks armed: a clean frame must still raise no flag
            cfg = {17'h00000, ms, 6'h03, lb & ms, 1'($urandom), 1'($urandom), ord, w};
            setup(ms ? 16'(2 + $urandom_range(2)) : 16'h0000);
            if (ms) begin
                u_peer.cap = 16'h0000;
                xf(sync_serial_pkg::off_tx_buffer, 1'b1, {16'h0000, d});
                rc();
                `CHK("busy", 1'b1, rd[28])
                for (int p = 0; p < 200 && rd[28] === 1'b1; p++) begin
                    rc();
                end
                `CHK("wire order", ord ? d & m : rev(d, w), u_peer.cap & m)
            end else begin
                @(posedge hclk);
                #1 u_peer.send(d, w, ord);
                repeat (12) @(posedge hclk);
            end
            `CHK("idle after", pol, sclk_out)
            xf(sync_serial_pkg::off_rx_buffer, 1'b0, 32'h0000_0000);
            rx_prev = rd[15:0];
            `CHK("rx data", (ms && !lb) ? ~d & m : d & m, rd[15:0])
            rc();
            // the shift counter rearms to zero when a frame ends
            `CHK("bit count", 4'h0, rd[19:16])
            `CHK("busy end", 1'b0, rd[28])
            `CHK("no flags", 4'h0, rd[27:24])
        end
        // slave clocked four times too slow, rate check and auto restart on
        cfg = 32'h0000_180f;
        setup(16'h0000);
        @(posedge hclk);
        #1 u_peer.send(d, 4'hf, 1'b1);
        repeat (12) @(posedge hclk);
        xf(sync_serial_pkg::off_rx_buffer, 1'b0, 32'h0000_0000);
        `CHK("rx kept", rx_prev, rd[15:0])
        xf(sync_serial_pkg::off_error_clear, 1'b1, 32'h0000_0000);
        rc();
        `CHK("rate flag", 1'b1, rd[27])
        xf(sync_serial_pkg::off_error_clear, 1'b1, 32'h0000_0800);
        rc();
        `CHK("flag cleared", 1'b0, rd[27])
        close_out();
    end
endmodule : sync_serial_channel_test
`default_nettype wire

// File: hdl/pin_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int width = 2
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous levels in, synchronised levels out
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    // ****************************************
    // per-bit chain
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < width; i = i + 1) begin : g_bit
            logic meta_ff;
            logic stable_ff;
            // first stage feeds only the second one
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    meta_ff <= 1'b0;
                    stable_ff <= 1'b0;
                end else begin
                    meta_ff <= async_in[i];
                    stable_ff <= meta_ff;
                end
            end
            assign sync_out[i] = stable_ff;
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

// File: hdl/sync_serial_channel.sv
// synchronous serial channel: control register, shift engine and ahb-lite slave
//
// What this block does
// - frame is width field plus one, order selectable
// - phase select picks shifting and latching edges
// - polarity select sets idle level, leading edge
// - loopback routes transmit output into receiver
// - four enables gate the four error checks
// - rate error with auto restart aborts channel
// - master drives shift clock, slave receives it
// - programming mode stops transmission and reception
// - operating mode runs, shows status and role
// - register view follows operate bit one write late
// - config fields only accessible in programming view
// - bit count readable only in operating view
// - shift counter steps once per latched bit
// - reserved control bits read zero
// - reset clears control register to zeros
// - busy flag stands through whole transfer
// - data change near latch edge flags phase
// - slave clock off by factor two flags rate
// - writing one to clear bit clears flag
`timescale 1ns/1ns
`default_nettype none
module sync_serial_channel (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // shift clock pin
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    // serial data pins
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_oe
);
    // ****************************************
    // control and data registers
    // ****************************************
    logic [3:0] width_ff;
    logic order_ff, phase_ff, pol_ff, loop_ff, auto_restart_on_rate_fault_ff, ms_ff, en_ff, view_ff;
    logic [3:0] chk_ff;
    logic [3:0] flags_ff;
    logic [15:0] br_ff, tb_ff, rb_ff;
    logic tb_fresh_ff, rb_full_ff;
    // bus state
    logic wr_ph_ff, rd_wait_ff, rd_ctl_ff;
    logic [7:0] addr_ff;
    logic [31:0] hrdata_ff;
    // engine state
    logic busy_ff, start_ff, sclk_ff;
    logic [4:0] cnt_ff;
    logic [15:0] txs_ff, rxs_ff, baud_ff;
    logic [18:0] per_ff;
    logic rx_d_ff, chg_d_ff;
    logic [1:0] hold_ff;
    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [1:0] pins_sync;
    logic s_sclk_d_ff;
    pin_sync #(.width(sync_serial_pkg::sync_stages)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({serial_in, sclk_in}),
        .sync_out(pins_sync)
    );
    wire s_sclk = pins_sync[0];
    wire s_data = pins_sync[1];
    // ****************************************
    // bus decode
    // ****************************************
    wire take = hsel && hready && htrans[1];
    wire wr_ctl = wr_ph_ff && (addr_ff == sync_serial_pkg::off_control);
    wire wr_tb = wr_ph_ff && (addr_ff == sync_serial_pkg::off_tx_buffer);
    wire wr_br = wr_ph_ff && (addr_ff == sync_serial_pkg::off_baud_reload);
    wire wr_clr = wr_ph_ff && (addr_ff == sync_serial_pkg::off_error_clear);
    wire rd_rb = rd_wait_ff && (addr_ff == sync_serial_pkg::off_rx_buffer);
    wire [3:0] clr_bits = wr_clr ? hwdata[sync_serial_pkg::clear_lsb +: 4] : 4'h0;
    // programming view: config fields; operating view: status, count and role
    wire [31:0] ctl_prog = {16'h0000, en_ff, ms_ff, 1'b0, auto_restart_on_rate_fault_ff, chk_ff, loop_ff, pol_ff, phase_ff, order_ff,
        width_ff};
    wire [31:0] ctl_oper = {3'h0, busy_ff, flags_ff, 4'h0, cnt_ff[3:0], en_ff, ms_ff, 14'h0000};
    wire [31:0] ctl_read = view_ff ? ctl_oper : ctl_prog;
    wire [31:0] rd_mux = (addr_ff == sync_serial_pkg::off_control) ? ctl_read :
        (addr_ff == sync_serial_pkg::off_tx_buffer) ? {16'h0000, tb_ff} :
        (addr_ff == sync_serial_pkg::off_rx_buffer) ? {16'h0000, rb_ff} :
        (addr_ff == sync_serial_pkg::off_baud_reload) ? {16'h0000, br_ff} : 32'h0000_0000;
    assign hrdata = hrdata_ff;
    assign hreadyout = !rd_wait_ff;
    assign hresp = 1'b0;
    // ****************************************
    // edge events
    // ****************************************
    wire m_tick = busy_ff && ms_ff && (baud_ff == 16'h0000);
    wire s_edge = !ms_ff && en_ff && (s_sclk != s_sclk_d_ff);
    wire s_lead = s_edge && (s_sclk != pol_ff);
    wire s_go = s_lead && !busy_ff;
    wire lead_ev = (m_tick && (sclk_ff == pol_ff)) || (s_lead && busy_ff) || s_go;
    wire trail_ev = (m_tick && (sclk_ff != pol_ff)) || (s_edge && !s_lead && busy_ff);
    wire latch_ev = phase_ff ? lead_ev : trail_ev;
    wire shift_ev = (phase_ff ? trail_ev : lead_ev) && (cnt_ff != 5'h00 || phase_ff);
    wire [4:0] frame_len = {1'b0, width_ff} + 5'h01;
    wire [4:0] nxt_cnt = latch_ev ? cnt_ff + 5'h01 : cnt_ff;
    wire done_ev = trail_ev && (nxt_cnt == frame_len);
    // ****************************************
    // data paths
    // ****************************************
    wire tx_bit = order_ff ? txs_ff[width_ff] : txs_ff[0];
    wire rx_bit = loop_ff ? tx_bit : s_data;
    wire [15:0] nxt_rxs = order_ff ? {rxs_ff[14:0], rx_bit} : {rx_bit, rxs_ff[15:1]};
    wire [3:0] align = 4'hf - width_ff;
    // stale bits of an earlier, longer frame must stay out of the word
    wire [15:0] word_mask = 16'hffff >> align;
    // with leading-edge latching the last edge is a shift edge, so take the held word
    wire [15:0] rx_src = latch_ev ? nxt_rxs : rxs_ff;
    wire [15:0] rx_word = (order_ff ? rx_src : (rx_src >> align)) & word_mask;
    wire [15:0] nxt_txs = order_ff ? {txs_ff[14:0], 1'b0} : {1'b0, txs_ff[15:1]};
    assign serial_out = tx_bit;
    assign serial_oe = en_ff;
    assign sclk_out = sclk_ff;
    assign sclk_oe = ms_ff;
    // ****************************************
    // error detection
    // ****************************************
    wire chg = (s_data != rx_d_ff);
    wire [18:0] exp_per = {2'b00, br_ff, 1'b0} + 19'h00002;
    wire per_bad = (per_ff > {exp_per[17:0], 1'b0}) || ({per_ff[17:0], 1'b0} < exp_per);
    wire [3:0] err_ev;
    assign err_ev[sync_serial_pkg::err_tx] = chk_ff[0] && s_go && !tb_fresh_ff;
    assign err_ev[sync_serial_pkg::err_rx] = chk_ff[1] && done_ev && rb_full_ff;
    assign err_ev[sync_serial_pkg::err_phase] = chk_ff[2] && busy_ff && !loop_ff &&
        ((latch_ev && (chg || chg_d_ff)) || (hold_ff != 2'h0 && chg));
    assign err_ev[sync_serial_pkg::err_rate] = chk_ff[3] && !ms_ff && busy_ff && cnt_ff != 5'h00 &&
        ((lead_ev && per_bad) || (per_ff > {exp_per[17:0], 1'b0}));
    // auto restart drops the frame; also drop it when leaving operating mode
    wire abort = (auto_restart_on_rate_fault_ff && err_ev[sync_serial_pkg::err_rate]) || !en_ff;
    // ****************************************
    // bus slave
    // ****************************************
    // reads take one wait state so a write just before them is already visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            rd_ctl_ff <= 1'b0;
            addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wr_ph_ff <= take && hwrite;
            rd_wait_ff <= take && !hwrite;
            if (take) begin
                addr_ff <= haddr[7:0];
            end
            if (rd_wait_ff) begin
                hrdata_ff <= rd_mux;
                rd_ctl_ff <= (addr_ff == sync_serial_pkg::off_control);
            end
        end
    end
    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // bit 13 is reserved and has no flop
            {en_ff, ms_ff, auto_restart_on_rate_fault_ff, chk_ff, loop_ff, pol_ff, phase_ff, order_ff, width_ff} <=
                {sync_serial_pkg::control_reset[15:14], sync_serial_pkg::control_reset[12:0]};
            view_ff <= 1'b0;
        end else if (wr_ctl) begin
            view_ff <= en_ff;
            en_ff <= hwdata[sync_serial_pkg::operate_bit];
            ms_ff <= hwdata[sync_serial_pkg::master_bit];
            if (!view_ff) begin
                width_ff <= hwdata[sync_serial_pkg::width_lsb +: 4];
                order_ff <= hwdata[sync_serial_pkg::order_bit];
                phase_ff <= hwdata[sync_serial_pkg::phase_bit];
                pol_ff <= hwdata[sync_serial_pkg::polarity_bit];
                loop_ff <= hwdata[sync_serial_pkg::loopback_bit];
                chk_ff <= hwdata[sync_serial_pkg::check_lsb +: 4];
                auto_restart_on_rate_fault_ff <= hwdata[sync_serial_pkg::auto_restart_bit];
            end
        end
    end
    // ****************************************
    // buffers, baud reload and flags
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            br_ff <= sync_serial_pkg::baud_reset;
            tb_ff <= 16'h0000;
            rb_ff <= 16'h0000;
            tb_fresh_ff <= 1'b0;
            rb_full_ff <= 1'b0;
            flags_ff <= 4'h0;
        end else begin
            if (wr_br) begin
                br_ff <= hwdata[15:0];
            end
            if (wr_tb) begin
                tb_ff <= hwdata[15:0];
            end
            tb_fresh_ff <= wr_tb || (tb_fresh_ff && !start_ff && !s_go);
            if (done_ev) begin
                rb_ff <= rx_word;
            end
            rb_full_ff <= done_ev || (rb_full_ff && !rd_rb);
            // a new event beats a clear in the same cycle
            flags_ff <= err_ev | (flags_ff & ~clr_bits);
        end
    end
    // ****************************************
    // shift engine
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_ff <= 1'b0;
            start_ff <= 1'b0;
            sclk_ff <= 1'b0;
            cnt_ff <= 5'h00;
            txs_ff <= 16'h0000;
            rxs_ff <= 16'h0000;
            baud_ff <= 16'h0000;
        end else begin
            start_ff <= wr_tb && en_ff && ms_ff && !busy_ff;
            if (abort || done_ev) begin
                busy_ff <= 1'b0;
                cnt_ff <= 5'h00;
                sclk_ff <= pol_ff;
            end else if (!busy_ff && !s_go) begin
                busy_ff <= start_ff;
                sclk_ff <= pol_ff;
                txs_ff <= tb_ff;
                baud_ff <= br_ff;
            end else begin
                busy_ff <= 1'b1;
                cnt_ff <= nxt_cnt;
                if (latch_ev) begin
                    rxs_ff <= nxt_rxs;
                end
                if (shift_ev) begin
                    txs_ff <= nxt_txs;
                end
                if (m_tick) begin
                    sclk_ff <= !sclk_ff;
                    baud_ff <= br_ff;
                end else if (ms_ff) begin
                    baud_ff <= baud_ff - 16'h0001;
                end
            end
        end
    end
    // ****************************************
    // check helpers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_sclk_d_ff <= 1'b0;
            rx_d_ff <= 1'b0;
            chg_d_ff <= 1'b0;
            hold_ff <= 2'h0;
            per_ff <= 19'h00000;
        end else begin
            s_sclk_d_ff <= s_sclk;
            rx_d_ff <= s_data;
            chg_d_ff <= chg;
            hold_ff <= latch_ev ? sync_serial_pkg::phase_win_after : (hold_ff != 2'h0 ? hold_ff - 2'h1 : 2'h0);
            // saturating period count between leading edges
            per_ff <= lead_ev ? 19'h00001 : (per_ff != 19'h7ffff ? per_ff + 19'h00001 : per_ff);
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    property p_idle_clock;
        @(posedge hclk) disable iff (!hresetn) (!busy_ff && !$past(busy_ff) && ms_ff && $stable(pol_ff)) |->
            (sclk_out == pol_ff);
    endproperty
    a_idle_clock: assert property (p_idle_clock) else $error("idle master clock not at idle level");
    property p_prog_stops;
        @(posedge hclk) disable iff (!hresetn) !en_ff |=> !busy_ff;
    endproperty
    a_prog_stops: assert property (p_prog_stops) else $error("transfer runs in programming mode");
    property p_busy_start;
        @(posedge hclk) disable iff (!hresetn) (start_ff && en_ff) |=> busy_ff;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy not raised at master start");
    property p_count_bound;
        @(posedge hclk) disable iff (!hresetn) busy_ff |-> (cnt_ff <= frame_len);
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("shift count beyond frame length");
    property p_count_step;
        @(posedge hclk) disable iff (!hresetn) (busy_ff && latch_ev && !done_ev && !abort) |=>
            (cnt_ff == $past(cnt_ff) + 5'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("shift count did not step");
    property p_rx_clean;
        @(posedge hclk) disable iff (!hresetn) done_ev |=> ((rb_ff & ~$past(word_mask)) == 16'h0000);
    endproperty
    a_rx_clean: assert property (p_rx_clean) else $error("received word holds bits beyond frame");
    property p_loop;
        @(posedge hclk) disable iff (!hresetn) (loop_ff && busy_ff && latch_ev && !done_ev && !abort) |=>
            ((order_ff ? rxs_ff[0] : rxs_ff[15]) == $past(serial_out));
    endproperty
    a_loop: assert property (p_loop) else $error("loopback not routing transmit output");
    property p_reserved;
        @(posedge hclk) disable iff (!hresetn) (hreadyout && rd_ctl_ff) |->
            (hrdata[13] == 1'b0 && hrdata[23:20] == 4'h0 && hrdata[31:29] == 3'h0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved control bits read nonzero");
    property p_view;
        @(posedge hclk) disable iff (!hresetn) wr_ctl |=> (view_ff == $past(en_ff)) ##1
            ($past(wr_ctl) || view_ff == $past(view_ff));
    endproperty
    a_view: assert property (p_view) else $error("view did not follow previous operate bit");
    property p_clear;
        @(posedge hclk) disable iff (!hresetn) (clr_bits[0] && !err_ev[0]) |=> !flags_ff[0];
    endproperty
    a_clear: assert property (p_clear) else $error("tx stale flag not cleared");
    property p_phase_off;
        @(posedge hclk) disable iff (!hresetn) !chk_ff[2] |=> !$rose(flags_ff[2]);
    endproperty
    a_phase_off: assert property (p_phase_off) else $error("phase flag set while check disabled");
    property p_auto_restart;
        @(posedge hclk) disable iff (!hresetn) (auto_restart_on_rate_fault_ff && err_ev[3]) |=> (!busy_ff && cnt_ff == 5'h00);
    endproperty
    a_auto_restart: assert property (p_auto_restart) else $error("rate fault did not restart channel");
    property p_role_pin;
        @(posedge hclk) disable iff (!hresetn) (m_tick && !abort) |=> (sclk_oe && sclk_out != $past(sclk_out));
    endproperty
    a_role_pin: assert property (p_role_pin) else $error("clock pin drive does not follow role");
endmodule : sync_serial_channel
`default_nettype wire

// File: hdl/sync_serial_pkg.sv
// constants of the synchronous serial channel control block
package sync_serial_pkg;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] off_control = 8'h04;
    localparam logic [7:0] off_tx_buffer = 8'h08;
    localparam logic [7:0] off_rx_buffer = 8'h0c;
    localparam logic [7:0] off_baud_reload = 8'h10;
    localparam logic [7:0] off_error_clear = 8'h14;
    // ****************************************
    // control register fields, programming view
    // ****************************************
    localparam int width_lsb = 0;
    localparam int order_bit = 4;
    localparam int phase_bit = 5;
    localparam int polarity_bit = 6;
    localparam int loopback_bit = 7;
    localparam int check_lsb = 8;
    localparam int auto_restart_bit = 12;
    localparam int master_bit = 14;
    localparam int operate_bit = 15;
    // ****************************************
    // control register fields, operating view
    // ****************************************
    localparam int count_lsb = 16;
    localparam int flag_lsb = 24;
    localparam int busy_bit = 28;
    // error clear register: bits 8..11 map onto flags 0..3
    localparam int clear_lsb = 8;
    // error classes: 0 tx stale, 1 rx overrun, 2 phase slip, 3 rate deviation
    localparam int err_tx = 0;
    localparam int err_rx = 1;
    localparam int err_phase = 2;
    localparam int err_rate = 3;
    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [31:0] control_reset = 32'h0000_0000;
    localparam logic [15:0] baud_reset = 16'h0000;
    localparam logic [1:0] phase_win_after = 2'h2;
    localparam int sync_stages = 2;
endpackage : sync_serial_pkg
